/* File: dsc_top.v */
// Deep sleep control: sleep mode choice, wake source gating, brown-out flag and pin hold
//
// Function
// - Select bit set: sleep instruction enters deep sleep; clear: ordinary sleep.
// - Deep sleep only if sleep follows select within two instruction cycles.
// - High byte bits 6..2 and low byte bits 7..3 read zero.
// - Module-on bit keeps the ultra-low-power wake module running in deep sleep.
// - Clock-calendar block bit set ignores calendar wake; clear lets it wake.
// - ULP block bit clear lets ULP source wake, only with module on.
// - Brown-out flag set on armed dip above trip level during deep sleep.
// - Pins held after deep sleep wake until software clears release bit.
// - Control bits reset zero; flag and release clear only on power-up.
`timescale 1ns/10ps
`include "dsc_map.vh"
module dsc_top
(
  input wire clk_in,                        // Instruction clock, 100 MHz
  input wire rstn_in,                       // Power-on reset, active low, asynchronous
  input wire sys_reset_in,                  // Ordinary device reset pulse
  input wire sleep_instr_in,                // Sleep instruction executes this cycle
  input wire wake_in,                       // Ordinary wake event (interrupt, reset pin)
  input wire rtc_event_in,                  // Real time clock calendar alarm
  input wire ulp_event_in,                  // Ultra-low-power wake event
  input wire brownout_arm_in,               // Deep sleep brown-out detection armed
  input wire supply_below_arm_in,           // Supply below arming level
  input wire supply_below_trip_in,          // Supply below brownout trip level
  input wire [`DSC_AW-1:0] s_axi_awaddr_in, // Write address
  input wire [2:0] s_axi_awprot_in,         // Write protection, unused
  input wire s_axi_awvalid_in,              // Write address valid
  output wire s_axi_awready_out,            // Write address ready
  input wire [31:0] s_axi_wdata_in,         // Write data
  input wire [3:0] s_axi_wstrb_in,          // Write byte enables
  input wire s_axi_wvalid_in,               // Write data valid
  output wire s_axi_wready_out,             // Write data ready
  output wire [1:0] s_axi_bresp_out,        // Write response
  output wire s_axi_bvalid_out,             // Write response valid
  input wire s_axi_bready_in,               // Write response ready
  input wire [`DSC_AW-1:0] s_axi_araddr_in, // Read address
  input wire [2:0] s_axi_arprot_in,         // Read protection, unused
  input wire s_axi_arvalid_in,              // Read address valid
  output wire s_axi_arready_out,            // Read address ready
  output wire [31:0] s_axi_rdata_out,       // Read data
  output wire [1:0] s_axi_rresp_out,        // Read response
  output wire s_axi_rvalid_out,             // Read data valid
  input wire s_axi_rready_in,               // Read data ready
  output wire sleep_out,                    // Ordinary sleep in progress
  output wire deep_sleep_out,               // Deep sleep in progress
  output wire ulp_module_on_out,            // Ultra-low-power wake module powered
  output wire pin_hold_out,                 // I/O pins frozen at pre-sleep state
  output wire wake_out,                     // One-cycle pulse on any wake
  output wire irq_out                       // Level interrupt
);

////////////////////////////////////////////////////////////////////////////////
// Reset and state encoding

localparam [2:0] ST_RUN = 3'h1;
localparam [2:0] ST_SLEEP = 3'h2;
localparam [2:0] ST_DEEP = 3'h4;

wire rstn;
wire wr_en;
wire [`DSC_AW-1:0] wr_addr;
wire [7:0] wr_data;
reg wr_err;
reg rd_err;
reg [7:0] rd_data;

reg [2:0] state_q;
reg [2:0] state_d;
reg deep_sel_q;
reg ulp_on_q;
reg rtc_block_q;
reg ulp_block_q;
reg bor_flag_q;
reg release_q;
reg [1:0] arm_cnt_q;
reg [`DSC_IRQ_N-1:0] irq_stat_q;
reg [`DSC_IRQ_N-1:0] irq_mask_q;
reg irq_q;
reg sleep_q;
reg deep_q;
reg ulp_pwr_q;
reg hold_q;
reg wake_q;

wire wr_hi;
wire wr_lo;
wire wr_stat;
wire wr_mask;
wire sel_rise;
wire enter_deep;
wire enter_sleep;
wire deep_wake;
wire sleep_wake;
wire bor_event;
wire lapse;
wire [`DSC_IRQ_N-1:0] irq_evt;

dsc_rst_sync u_rst
(
  .clk_in(clk_in),
  .rstn_in(rstn_in),
  .rstn_out(rstn)
);

////////////////////////////////////////////////////////////////////////////////
// Bus front end and decode

dsc_axil u_bus
(
  .clk_in(clk_in),
  .rstn_in(rstn),
  .awaddr_in(s_axi_awaddr_in),
  .awvalid_in(s_axi_awvalid_in),
  .awready_out(s_axi_awready_out),
  .wdata_in(s_axi_wdata_in),
  .wstrb_in(s_axi_wstrb_in),
  .wvalid_in(s_axi_wvalid_in),
  .wready_out(s_axi_wready_out),
  .bresp_out(s_axi_bresp_out),
  .bvalid_out(s_axi_bvalid_out),
  .bready_in(s_axi_bready_in),
  .araddr_in(s_axi_araddr_in),
  .arvalid_in(s_axi_arvalid_in),
  .arready_out(s_axi_arready_out),
  .rdata_out(s_axi_rdata_out),
  .rresp_out(s_axi_rresp_out),
  .rvalid_out(s_axi_rvalid_out),
  .rready_in(s_axi_rready_in),
  .wr_en_out(wr_en),
  .wr_addr_out(wr_addr),
  .wr_data_out(wr_data),
  .wr_err_in(wr_err),
  .rd_en_out(),
  .rd_data_in(rd_data),
  .rd_err_in(rd_err)
);

assign wr_hi = wr_en && (wr_addr == `DSC_ADDR_CTRL_HIGH);
assign wr_lo = wr_en && (wr_addr == `DSC_ADDR_CTRL_LOW);
assign wr_stat = wr_en && (wr_addr == `DSC_ADDR_IRQ_STATUS);
assign wr_mask = wr_en && (wr_addr == `DSC_ADDR_IRQ_MASK);

always @*
begin
  wr_err = 1'b0;
  case (wr_addr)
    `DSC_ADDR_CTRL_HIGH, `DSC_ADDR_CTRL_LOW, `DSC_ADDR_IRQ_STATUS, `DSC_ADDR_IRQ_MASK:
      wr_err = 1'b0;
    default:
      wr_err = 1'b1;
  endcase
end

// Unimplemented and reserved positions are never stored, so they read zero
always @*
begin
  rd_data = 8'h00;
  rd_err = 1'b0;
  case (s_axi_araddr_in)
    `DSC_ADDR_CTRL_HIGH:
      rd_data = {deep_sel_q, 5'h00, ulp_on_q, rtc_block_q};
    `DSC_ADDR_CTRL_LOW:
      rd_data = {5'h00, ulp_block_q, bor_flag_q, release_q};
    `DSC_ADDR_IRQ_STATUS:
      rd_data = {5'h00, irq_stat_q};
    `DSC_ADDR_IRQ_MASK:
      rd_data = {5'h00, irq_mask_q};
    default:
      rd_err = 1'b1;
  endcase
end

////////////////////////////////////////////////////////////////////////////////
// Control bits

// Ordinary resets and deep sleep wake clear these; only power-up clears the flag and release
always @(posedge clk_in or negedge rstn)
begin
  if (!rstn)
  begin
    deep_sel_q <= 1'b0;
    ulp_on_q <= 1'b0;
    rtc_block_q <= 1'b0;
    ulp_block_q <= 1'b0;
  end
  else if (sys_reset_in || deep_wake)
  begin
    deep_sel_q <= 1'b0;
    ulp_on_q <= 1'b0;
    rtc_block_q <= 1'b0;
    ulp_block_q <= 1'b0;
  end
  else
  begin
    if (wr_hi)
    begin
      deep_sel_q <= wr_data[`DSC_HI_DEEP_SEL];
      ulp_on_q <= wr_data[`DSC_HI_ULP_ON];
      rtc_block_q <= wr_data[`DSC_HI_RTC_BLOCK];
    end
    if (wr_lo)
    begin
      ulp_block_q <= wr_data[`DSC_LO_ULP_BLOCK];
    end
  end
end

// Arming window opens when the select bit goes from zero to one
assign sel_rise = wr_hi && wr_data[`DSC_HI_DEEP_SEL] && !deep_sel_q;
assign lapse = (arm_cnt_q == 2'h1) && !(sleep_instr_in && state_q == ST_RUN);

always @(posedge clk_in or negedge rstn)
begin
  if (!rstn)
  begin
    arm_cnt_q <= 2'h0;
  end
  else if (sel_rise)
  begin
    arm_cnt_q <= `DSC_ARM_CYC;
  end
  else if (sys_reset_in || enter_deep || enter_sleep)
  begin
    arm_cnt_q <= 2'h0;
  end
  else if (arm_cnt_q != 2'h0)
  begin
    arm_cnt_q <= arm_cnt_q - 2'h1;
  end
end

// Lapsed arming falls back to ordinary sleep
assign enter_deep = (state_q == ST_RUN) && sleep_instr_in && deep_sel_q && (arm_cnt_q != 2'h0);
assign enter_sleep = (state_q == ST_RUN) && sleep_instr_in && !enter_deep;

// Calendar wake unless blocked; ULP wake needs module on and no block
assign deep_wake = (state_q == ST_DEEP) &&
  (wake_in || (rtc_event_in && !rtc_block_q) || (ulp_event_in && !ulp_block_q && ulp_on_q));
assign sleep_wake = (state_q == ST_SLEEP) && wake_in;

////////////////////////////////////////////////////////////////////////////////
// Sleep state machine

always @*
begin
  state_d = state_q;
  case (state_q)
    ST_RUN:
      if (enter_deep)
        state_d = ST_DEEP;
      else if (enter_sleep)
        state_d = ST_SLEEP;
    ST_SLEEP:
      if (sleep_wake)
        state_d = ST_RUN;
    ST_DEEP:
      if (deep_wake)
        state_d = ST_RUN;
    default:
      state_d = ST_RUN;
  endcase
end

always @(posedge clk_in or negedge rstn)
begin
  if (!rstn)
  begin
    state_q <= ST_RUN;
  end
  else if (sys_reset_in)
  begin
    state_q <= ST_RUN;
  end
  else
  begin
    state_q <= state_d;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Brown-out flag and pin release

// A dip that crosses the trip level is a full brownout reset, not this flag
assign bor_event = (state_q == ST_DEEP) && brownout_arm_in && supply_below_arm_in && !supply_below_trip_in;

// Set wins over a software write in the same cycle
always @(posedge clk_in or negedge rstn)
begin
  if (!rstn)
  begin
    bor_flag_q <= 1'b0;
    release_q <= 1'b0;
  end
  else
  begin
    if (bor_event)
      bor_flag_q <= 1'b1;
    else if (wr_lo)
      bor_flag_q <= wr_data[`DSC_LO_BOR_FLAG];
    if (enter_deep)
      release_q <= 1'b1;
    else if (wr_lo)
      release_q <= wr_data[`DSC_LO_RELEASE];
  end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupts

assign irq_evt[`DSC_IRQ_WAKE] = deep_wake || sleep_wake;
assign irq_evt[`DSC_IRQ_BOR] = bor_event && !bor_flag_q;
assign irq_evt[`DSC_IRQ_LAPSE] = lapse;

genvar gi;
generate
  for (gi = 0; gi < `DSC_IRQ_N; gi = gi + 1)
  begin : g_irq
    always @(posedge clk_in or negedge rstn)
    begin
      if (!rstn)
        irq_stat_q[gi] <= 1'b0;
      else if (irq_evt[gi])
        irq_stat_q[gi] <= 1'b1;
      else if (wr_stat && wr_data[gi])
        irq_stat_q[gi] <= 1'b0;
    end
  end
endgenerate

always @(posedge clk_in or negedge rstn)
begin
  if (!rstn)
  begin
    irq_mask_q <= `DSC_IRQ_RST;
    irq_q <= 1'b0;
  end
  else
  begin
    if (wr_mask)
      irq_mask_q <= wr_data[`DSC_IRQ_N-1:0];
    irq_q <= |(irq_stat_q & irq_mask_q);
  end
end

////////////////////////////////////////////////////////////////////////////////
// Registered outputs

always @(posedge clk_in or negedge rstn)
begin
  if (!rstn)
  begin
    sleep_q <= 1'b0;
    deep_q <= 1'b0;
    ulp_pwr_q <= 1'b0;
    hold_q <= 1'b0;
    wake_q <= 1'b0;
  end
  else
  begin
    sleep_q <= (state_d == ST_SLEEP);
    deep_q <= (state_d == ST_DEEP);
    ulp_pwr_q <= (state_d == ST_DEEP) && ulp_on_q;
    hold_q <= (state_d == ST_DEEP) || (release_q && !(wr_lo && !wr_data[`DSC_LO_RELEASE])) || enter_deep;
    wake_q <= deep_wake || sleep_wake;
  end
end

assign sleep_out = sleep_q;
assign deep_sleep_out = deep_q;
assign ulp_module_on_out = ulp_pwr_q;
assign pin_hold_out = hold_q;
assign wake_out = wake_q;
assign irq_out = irq_q;

endmodule

/* File: dsc_map.vh */
// Register map, field positions and timing counts of the deep sleep control block
`ifndef DSC_MAP_VH
`define DSC_MAP_VH

// Register indices; byte address is four times the index
`define DSC_IDX_CTRL_LOW 16'h0F4C
`define DSC_IDX_CTRL_HIGH 16'h0F4D
`define DSC_IDX_IRQ_STATUS 16'h0F4E
`define DSC_IDX_IRQ_MASK 16'h0F4F
`define DSC_ADDR_CTRL_LOW 16'h3D30
`define DSC_ADDR_CTRL_HIGH 16'h3D34
`define DSC_ADDR_IRQ_STATUS 16'h3D38
`define DSC_ADDR_IRQ_MASK 16'h3D3C
`define DSC_AW 16

// High control byte fields
`define DSC_HI_DEEP_SEL 7
`define DSC_HI_RSVD 2
`define DSC_HI_ULP_ON 1
`define DSC_HI_RTC_BLOCK 0

// Low control byte fields
`define DSC_LO_ULP_BLOCK 2
`define DSC_LO_BOR_FLAG 1
`define DSC_LO_RELEASE 0

// Interrupt status and mask fields
`define DSC_IRQ_WAKE 0
`define DSC_IRQ_BOR 1
`define DSC_IRQ_LAPSE 2
`define DSC_IRQ_N 3

// Reset values
`define DSC_CTRL_RST 8'h00
`define DSC_IRQ_RST 3'h0

// Instruction cycles allowed between select and sleep
`define DSC_ARM_CYC 2'h2

// Bus responses
`define DSC_RESP_OKAY 2'h0
`define DSC_RESP_SLVERR 2'h2

`endif

/* File: dsc_rst_sync.v */
// Two flip-flop release synchroniser for the active-low reset
`timescale 1ns/10ps
module dsc_rst_sync
(
  input wire clk_in,   // Clock
  input wire rstn_in,  // Asynchronous reset, active low
  output wire rstn_out // Synchronised reset, active low
);

reg meta_q;
reg sync_q;

always @(posedge clk_in or negedge rstn_in)
begin
  if (!rstn_in)
  begin
    meta_q <= 1'b0;
    sync_q <= 1'b0;
  end
  else
  begin
    meta_q <= 1'b1;
    sync_q <= meta_q;
  end
end

assign rstn_out = sync_q;

endmodule

/* File: dsc_axil.v */
// AXI4-Lite slave front end: one write and one read outstanding, decode left to the parent
`timescale 1ns/10ps
`include "dsc_map.vh"
module dsc_axil
(
  input wire clk_in,                    // Clock
  input wire rstn_in,                   // Synchronised reset, active low
  input wire [`DSC_AW-1:0] awaddr_in,   // Write address
  input wire awvalid_in,                // Write address valid
  output wire awready_out,              // Write address ready
  input wire [31:0] wdata_in,           // Write data
  input wire [3:0] wstrb_in,            // Write byte enables
  input wire wvalid_in,                 // Write data valid
  output wire wready_out,               // Write data ready
  output wire [1:0] bresp_out,          // Write response
  output wire bvalid_out,               // Write response valid
  input wire bready_in,                 // Write response ready
  input wire [`DSC_AW-1:0] araddr_in,   // Read address
  input wire arvalid_in,                // Read address valid
  output wire arready_out,              // Read address ready
  output wire [31:0] rdata_out,         // Read data
  output wire [1:0] rresp_out,          // Read response
  output wire rvalid_out,               // Read data valid
  input wire rready_in,                 // Read data ready
  output wire wr_en_out,                // One-cycle register write strobe
  output wire [`DSC_AW-1:0] wr_addr_out, // Write address held
  output wire [7:0] wr_data_out,        // Low byte of write data
  input wire wr_err_in,                 // Write address unmapped
  output wire rd_en_out,                // Read taken this cycle
  input wire [7:0] rd_data_in,          // Read data for araddr_in
  input wire rd_err_in                  // Read address unmapped
);

reg aw_rdy_q;
reg w_rdy_q;
reg aw_full_q;
reg w_full_q;
reg [`DSC_AW-1:0] aw_addr_q;
reg [7:0] w_data_q;
reg w_lane_q;
reg bvalid_q;
reg [1:0] bresp_q;
reg ar_rdy_q;
reg rvalid_q;
reg [31:0] rdata_q;
reg [1:0] rresp_q;
wire do_wr;

// Both halves held and no response pending; byte lane 0 carries the register
assign do_wr = aw_full_q & w_full_q & ~bvalid_q;
assign wr_en_out = do_wr & w_lane_q;
assign wr_addr_out = aw_addr_q;
assign wr_data_out = w_data_q;
assign rd_en_out = arvalid_in & ar_rdy_q;

always @(posedge clk_in or negedge rstn_in)
begin
  if (!rstn_in)
  begin
    aw_rdy_q <= 1'b0;
    w_rdy_q <= 1'b0;
    aw_full_q <= 1'b0;
    w_full_q <= 1'b0;
    aw_addr_q <= {`DSC_AW{1'b0}};
    w_data_q <= 8'h00;
    w_lane_q <= 1'b0;
    bvalid_q <= 1'b0;
    bresp_q <= `DSC_RESP_OKAY;
  end
  else
  begin
    if (awvalid_in && aw_rdy_q)
    begin
      aw_rdy_q <= 1'b0;
      aw_full_q <= 1'b1;
      aw_addr_q <= awaddr_in;
    end
    else if (!aw_full_q)
    begin
      aw_rdy_q <= 1'b1;
    end
    if (wvalid_in && w_rdy_q)
    begin
      w_rdy_q <= 1'b0;
      w_full_q <= 1'b1;
      w_data_q <= wdata_in[7:0];
      w_lane_q <= wstrb_in[0];
    end
    else if (!w_full_q)
    begin
      w_rdy_q <= 1'b1;
    end
    if (do_wr)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_err_in ? `DSC_RESP_SLVERR : `DSC_RESP_OKAY;
    end
    else if (bvalid_q && bready_in)
    begin
      bvalid_q <= 1'b0;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
    end
  end
end

always @(posedge clk_in or negedge rstn_in)
begin
  if (!rstn_in)
  begin
    ar_rdy_q <= 1'b0;
    rvalid_q <= 1'b0;
    rdata_q <= 32'h00000000;
    rresp_q <= `DSC_RESP_OKAY;
  end
  else if (rd_en_out)
  begin
    ar_rdy_q <= 1'b0;
    rvalid_q <= 1'b1;
    rdata_q <= {24'h000000, rd_data_in};
    rresp_q <= rd_err_in ? `DSC_RESP_SLVERR : `DSC_RESP_OKAY;
  end
  else if (rvalid_q && rready_in)
  begin
    rvalid_q <= 1'b0;
    ar_rdy_q <= 1'b1;
  end
  else if (!rvalid_q)
  begin
    ar_rdy_q <= 1'b1;
  end
end

assign awready_out = aw_rdy_q;
assign wready_out = w_rdy_q;
assign bvalid_out = bvalid_q;
assign bresp_out = bresp_q;
assign arready_out = ar_rdy_q;
assign rvalid_out = rvalid_q;
assign rdata_out = rdata_q;
assign rresp_out = rresp_q;

endmodule

/* File: dsc_top_props.sv */
// Port-level checker of the deep sleep control block
`timescale 1ns/10ps
module dsc_top_props
(
  input wire clk_in,             // Clock
  input wire rstn_in,            // Power-on reset, active low
  input wire sleep_instr_in,     // Sleep instruction
  input wire wake_in,            // Generic wake
  input wire s_axi_arvalid_in,   // Read address valid
  input wire s_axi_arready_out,  // Read address ready
  input wire s_axi_rvalid_out,   // Read data valid
  input wire [31:0] s_axi_rdata_out, // Read data
  input wire sleep_out,          // Ordinary sleep
  input wire deep_sleep_out,     // Deep sleep
  input wire ulp_module_on_out,  // Wake module powered
  input wire pin_hold_out,       // Pins frozen
  input wire wake_out,           // Wake pulse
  input wire irq_out             // Interrupt
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);
  ////////////////////////////////////////////////////////////////////////////////
  AST_DEEP_FROM_SLEEP: assert property ($rose(deep_sleep_out) |-> $past(sleep_instr_in))
    else $error("deep sleep began without a sleep instruction");
  AST_SLEEP_FROM_SLEEP: assert property ($rose(sleep_out) |-> $past(sleep_instr_in))
    else $error("sleep began without a sleep instruction");
  AST_ONE_MODE: assert property (!(sleep_out && deep_sleep_out))
    else $error("both sleep modes at once");
  // One cycle of slack at wake, though the module flag falls in the same cycle as the state
  AST_ULP_ONLY_DEEP: assert property (ulp_module_on_out |-> deep_sleep_out || $past(deep_sleep_out))
    else $error("wake module powered outside deep sleep");
  AST_HOLD_IN_DEEP: assert property (deep_sleep_out |-> pin_hold_out)
    else $error("pins not held in deep sleep");
  AST_HOLD_KEPT: assert property ($fell(deep_sleep_out) |-> pin_hold_out ##1 pin_hold_out)
    else $error("pins released on wake");
  AST_WAKE_PULSE: assert property (wake_out |=> !wake_out)
    else $error("wake pulse longer than one cycle");
  AST_WAKE_ENDS: assert property (deep_sleep_out && wake_in |-> ##[1:3] !deep_sleep_out)
    else $error("wake did not end deep sleep");
  AST_READ_ZEROS: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h000000
    && s_axi_rdata_out[6:3] == 4'h0)
    else $error("unused bits read nonzero");
  AST_READ_ANSWER: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read answer late");
  AST_AR_ONE: assert property (s_axi_arvalid_in && s_axi_arready_out |=> !s_axi_arready_out)
    else $error("second read taken while one outstanding");
  cover property ($rose(deep_sleep_out));
  cover property ($rose(sleep_out));
  cover property ($rose(irq_out));
  cover property (wake_out && pin_hold_out);
endmodule

bind dsc_top dsc_top_props i_props (.*);

/* File: test_dsc_top.sv */
// Self-checking bench of the deep sleep control block
`timescale 1ns/10ps
`include "dsc_map.vh"
module test_dsc_top;
  logic clk_in = 1'b0, rstn_in = 1'b0, sys_reset_in = 1'b0, sleep_instr_in = 1'b0, wake_in = 1'b0;
  logic rtc_event_in = 1'b0, ulp_event_in = 1'b0, brownout_arm_in = 1'b0, supply_below_arm_in = 1'b0;
  logic supply_below_trip_in = 1'b0, s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
  logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
  logic [`DSC_AW-1:0] s_axi_awaddr_in = 16'h0000, s_axi_araddr_in = 16'h0000;
  logic [31:0] s_axi_wdata_in = 32'h00000000;
  logic [2:0] s_axi_awprot_in = 3'h0, s_axi_arprot_in = 3'h0;
  logic [3:0] s_axi_wstrb_in = 4'hF;
  wire s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  wire [1:0] s_axi_bresp_out, s_axi_rresp_out;
  wire [31:0] s_axi_rdata_out;
  wire sleep_out, deep_sleep_out, ulp_module_on_out, pin_hold_out, wake_out, irq_out;
  int err_count = 0;
  int n_checks = 0;
  logic [31:0] rd;
  logic [1:0] rs;
  typedef struct {logic [15:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r;} dsc_row_t;
  typedef struct {logic [7:0] hi; logic [7:0] lo; int d; logic [4:0] ev; logic dp; logic wk;} dsc_case_t;
  // Bit 2 of the high byte is never written as one
  dsc_row_t rows [7] = '{'{`DSC_ADDR_CTRL_HIGH, 32'h0000007B, 32'h00000003, `DSC_RESP_OKAY},
    '{`DSC_ADDR_CTRL_LOW, 32'hFFFFFFFF, 32'h00000007, `DSC_RESP_OKAY},
    '{`DSC_ADDR_CTRL_LOW, 32'h00000000, 32'h00000000, `DSC_RESP_OKAY},
    '{`DSC_ADDR_IRQ_MASK, 32'h00000007, 32'h00000007, `DSC_RESP_OKAY},
    '{`DSC_ADDR_IRQ_MASK, 32'h00000000, 32'h00000000, `DSC_RESP_OKAY},
    '{16'h0000, 32'h000000FF, 32'h00000000, `DSC_RESP_SLVERR},
    '{`DSC_ADDR_CTRL_HIGH, 32'h00000000, 32'h00000000, `DSC_RESP_OKAY}};
  // ev: [0] calendar [1] ulp [2] arm [3] below arm [4] below trip; d=1 misses the window
  dsc_case_t cases [9] = '{'{8'h80, 8'h00, 0, 5'h01, 1'b1, 1'b1}, '{8'h80, 8'h00, 1, 5'h00, 1'b0, 1'b0},
    '{8'h81, 8'h00, 0, 5'h01, 1'b1, 1'b0}, '{8'h82, 8'h00, 0, 5'h02, 1'b1, 1'b1},
    '{8'h82, 8'h04, 0, 5'h02, 1'b1, 1'b0}, '{8'h80, 8'h00, 0, 5'h02, 1'b1, 1'b0},
    '{8'h80, 8'h00, 0, 5'h0C, 1'b1, 1'b0}, '{8'h80, 8'h00, 0, 5'h1C, 1'b1, 1'b0},
    '{8'h80, 8'h00, 0, 5'h08, 1'b1, 1'b0}};

  dsc_top i_dut (.*);

  always #5 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD t=%0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // No cycle limit here: a missing answer is caught by the watchdog
  task wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do
    begin
      @(posedge clk_in);
      if (s_axi_awready_out === 1'b1) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out === 1'b1) s_axi_wvalid_in <= 1'b0;
    end
    while (s_axi_bvalid_out !== 1'b1);
    rs = s_axi_bresp_out;
    s_axi_bready_in <= 1'b0;
  endtask

  task rdr(input logic [15:0] a);
    @(posedge clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do
    begin
      @(posedge clk_in);
      if (s_axi_arready_out === 1'b1) s_axi_arvalid_in <= 1'b0;
    end
    while (s_axi_rvalid_out !== 1'b1);
    rd = s_axi_rdata_out;
    rs = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
  endtask

  task run_case(input dsc_case_t c);
    logic fl;
    fl = c.dp & c.ev[2] & c.ev[3] & !c.ev[4];
    wr(`DSC_ADDR_CTRL_LOW, {24'h000000, c.lo});
    wr(`DSC_ADDR_CTRL_HIGH, {24'h000000, c.hi});
    repeat (c.d) @(posedge clk_in);
    sleep_instr_in <= 1'b1;
    @(posedge clk_in);
    sleep_instr_in <= 1'b0;
    @(posedge clk_in);
    #1;
    chk(deep_sleep_out, c.dp, "deep sleep");
    chk(sleep_out, !c.dp, "ordinary sleep");
    chk(pin_hold_out, c.dp, "pin hold on entry");
    chk(ulp_module_on_out, c.dp & c.hi[1], "wake module");
    @(posedge clk_in);
    {supply_below_trip_in, supply_below_arm_in, brownout_arm_in, ulp_event_in, rtc_event_in} <= c.ev;
    @(posedge clk_in);
    {supply_below_trip_in, supply_below_arm_in, brownout_arm_in, ulp_event_in, rtc_event_in} <= 5'h00;
    #1;
    chk(wake_out, c.dp & c.wk, "wake pulse");
    repeat (3) @(posedge clk_in);
    #1;
    chk(deep_sleep_out, c.dp & !c.wk, "wake source");
    @(posedge clk_in);
    wake_in <= 1'b1;
    @(posedge clk_in);
    wake_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
    chk(pin_hold_out, c.dp, "pin hold after wake");
    rdr(`DSC_ADDR_CTRL_LOW);
    chk(rd, {29'h0, c.lo[2] & !c.dp, fl, c.dp}, "low byte after wake");
    wr(`DSC_ADDR_CTRL_LOW, 32'h00000000);
    wr(`DSC_ADDR_CTRL_HIGH, 32'h00000000);
    repeat (2) @(posedge clk_in);
    #1;
    chk(pin_hold_out, 1'b0, "pins released");
  endtask

  task conclude();
    $display("Checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #200000;
    err_count++;
    conclude();
  end

  initial
  begin
    repeat (12) @(posedge clk_in);
    rstn_in <= 1'b1;
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      chk(rs, rows[i].r, "write response");
      rdr(rows[i].a);
      chk(rs, rows[i].r, "read response");
      chk(rd, rows[i].q, "read data");
    end
    $display("Register rows done");
    foreach (cases[i]) run_case(cases[i]);
    $display("Sleep cases done");
    rdr(`DSC_ADDR_IRQ_STATUS);
    chk(rd, 32'h00000007, "status events");
    chk(irq_out, 1'b0, "masked interrupt");
    wr(`DSC_ADDR_IRQ_MASK, 32'h00000004);
    repeat (2) @(posedge clk_in);
    #1;
    chk(irq_out, 1'b1, "unmasked interrupt");
    wr(`DSC_ADDR_IRQ_STATUS, 32'h00000004);
    repeat (2) @(posedge clk_in);
    #1;
    chk(irq_out, 1'b0, "interrupt cleared");
    rdr(`DSC_ADDR_IRQ_STATUS);
    chk(rd, 32'h00000003, "status after clear");
    $display("Interrupt test done");
    // Ordinary reset keeps the release bit but clears control bits
    wr(`DSC_ADDR_CTRL_HIGH, 32'h00000003);
    wr(`DSC_ADDR_CTRL_LOW, 32'h00000005);
    @(posedge clk_in);
    sys_reset_in <= 1'b1;
    @(posedge clk_in);
    sys_reset_in <= 1'b0;
    rdr(`DSC_ADDR_CTRL_HIGH);
    chk(rd, 32'h00000000, "high after device reset");
    rdr(`DSC_ADDR_CTRL_LOW);
    chk(rd, 32'h00000001, "low after device reset");
    @(posedge clk_in);
    rstn_in <= 1'b0;
    repeat (12) @(posedge clk_in);
    rstn_in <= 1'b1;
    rdr(`DSC_ADDR_CTRL_LOW);
    chk(rd, 32'h00000000, "low after power-on");
    chk(pin_hold_out, 1'b0, "pins free after power-on");
    rdr(`DSC_ADDR_CTRL_HIGH);
    chk(rd, 32'h00000000, "high after power-on");
    rdr(`DSC_ADDR_IRQ_STATUS);
    chk(rd, 32'h00000000, "status after power-on");
    rdr(`DSC_ADDR_IRQ_MASK);
    chk(rd, 32'h00000000, "mask after power-on");
    $display("Reset test done");
    conclude();
  end
endmodule
